// ---- hw/pd_hold_pkg.sv ----
// package: constants and carrier types for the power-down hold block
package pd_hold_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int unsigned IO_W = 8;
  localparam int unsigned CORE_W = 8;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned RECOVERY_US = 1;
  // longest recovery rounds down to whole cycles
  localparam int unsigned RECOVERY_CYC = (RECOVERY_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [CNT_W-1:0] RECOVERY_CNT = CNT_W'(RECOVERY_CYC);
  localparam logic [CORE_W-1:0] CORE_RESET = 8'h00;
  localparam logic [IO_W-1:0] IO_RESET = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    st_run,
    st_hold,
    st_recover
  } mode_t;

  // pad group: level out, enable out
  typedef struct packed {
    logic [IO_W-1:0] dout;
    logic [IO_W-1:0] oe;
  } pad_out_t;

  typedef struct packed {
    mode_t mode;
    logic [CNT_W-1:0] cnt;
    logic [CORE_W-1:0] core;
    logic [IO_W-1:0] keep_in;
    logic [IO_W-1:0] pad_dout;
    logic [IO_W-1:0] pad_oe;
  } state_t;

endpackage : pd_hold_pkg

// ---- hw/pin_power_down_hold.sv ----
// pin-controlled power-down hold around a small piece of core logic
`timescale 1ns/100ps
`default_nettype none

module pin_power_down_hold (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pd_enable,
  input wire logic power_down_pin,
  input wire logic [pd_hold_pkg::IO_W-1:0] pad_in,
  input wire logic [pd_hold_pkg::CORE_W-1:0] core_next_in,
  input wire logic [pd_hold_pkg::IO_W-1:0] out_data_in,
  input wire logic [pd_hold_pkg::IO_W-1:0] out_oe_in,
  output logic [pd_hold_pkg::IO_W-1:0] pad_seen,
  output logic [pd_hold_pkg::CORE_W-1:0] core_state,
  output pd_hold_pkg::pad_out_t pad_out,
  output logic in_hold,
  output logic outputs_valid,
  output logic pin_cell_feedback
);
  import pd_hold_pkg::*;

  // ---------------------------------------------------------------
  // behaviour notes
  // ---------------------------------------------------------------
  // the hold request needs both the option and the pin, so a board
  // that leaves the pin floating high does nothing without the option.
  // hold and recovery share one frozen image: nothing is captured
  // until the mode is back in run, so the first edge in run is the
  // first edge that takes fresh inputs again.
  // the recovery count is loaded on the edge that sees the pin low;
  // a new request inside recovery goes straight back to hold and the
  // count is loaded afresh on the next exit.
  // ce low freezes everything, the recovery count included, so the
  // recovery time is counted in enabled edges, not in wall time.
  // reset is the only way to lose the held image.

  state_t s_reg;
  state_t s_next;
  logic hold_req;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign hold_req = pd_enable & power_down_pin;

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.mode)
      st_run: begin
        // normal path: inputs flow into core and pads
        s_next.core = core_next_in;
        s_next.keep_in = pad_in;
        s_next.pad_dout = out_data_in;
        s_next.pad_oe = out_oe_in;
        if (hold_req) begin
          s_next.mode = st_hold;
        end
      end
      st_hold: begin
        // nothing but the hold request (option and pin) is looked at here
        if (!hold_req) begin
          s_next.mode = st_recover;
          s_next.cnt = RECOVERY_CNT;
        end
      end
      st_recover: begin
        // held state is kept, logic restarts from it
        if (hold_req) begin
          s_next.mode = st_hold;
        end else if (s_reg.cnt <= 6'h01) begin
          s_next.mode = st_run;
          s_next.cnt = CNT_RESET;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h01;
        end
      end
      default: begin
        s_next.mode = st_run;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg.mode <= st_run;
      s_reg.cnt <= CNT_RESET;
      s_reg.core <= CORE_RESET;
      s_reg.keep_in <= IO_RESET;
      s_reg.pad_dout <= IO_RESET;
      s_reg.pad_oe <= IO_RESET;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pad_seen = s_reg.keep_in;
  assign core_state = s_reg.core;
  assign pad_out.dout = s_reg.pad_dout;
  assign pad_out.oe = s_reg.pad_oe;
  assign in_hold = (s_reg.mode != st_run);
  assign outputs_valid = (s_reg.mode == st_run);
  // pin macrocell feedback comes from core state, never from the pin
  assign pin_cell_feedback = s_reg.core[0];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  hold_freeze_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_hold) |=> $stable(s_reg.core) && $stable(s_reg.pad_dout))
    else $error("state changed during hold");

  hold_hiz_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_hold) |=> $stable(pad_out.oe))
    else $error("output enable changed during hold");

  keeper_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode != st_run) |=> $stable(pad_seen))
    else $error("keeper level changed during hold");

  enter_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_run && pd_enable && power_down_pin) |=> in_hold)
    else $error("hold not entered");

  no_option_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_run && !pd_enable) |=> !in_hold)
    else $error("hold without option");

  recover_a: assert property (@(posedge mclk) disable iff (rst)
    (s_reg.mode == st_hold && !hold_req && ce) ##1 (ce && !hold_req)[*8]
    |-> ##[0:40] outputs_valid || !ce || hold_req)
    else $error("recovery too long");

  resume_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_recover && s_next.mode == st_run) |=> core_state == $past(s_reg.core))
    else $error("resume lost held state");

  inputs_blocked_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_hold) |=> pad_seen == $past(pad_seen))
    else $error("input passed during hold");

  run_follow_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_run && !hold_req) |=> pin_cell_feedback == $past(core_next_in[0]))
    else $error("pin macrocell feedback not usable");

  // ---------------------------------------------------------------
  // checks: run path, clock enable and staying in hold
  // ---------------------------------------------------------------
  ce_freeze_a: assert property (@(posedge mclk) disable iff (rst)
    (!ce)
    |=> $stable(s_reg))
    else $error("state moved with clock enable low");

  run_pads_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_run)
    |=> pad_out.dout == $past(out_data_in) && pad_out.oe == $past(out_oe_in))
    else $error("pad outputs do not follow core in run");

  run_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_run)
    |=> pad_seen == $past(pad_in))
    else $error("kept input level does not follow pad in run");

  hold_stay_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_hold && hold_req)
    |=> s_reg.mode == st_hold)
    else $error("hold left while pin high");

  // ---------------------------------------------------------------
  // checks: recovery
  // ---------------------------------------------------------------
  hold_exit_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_hold && !hold_req)
    |=> s_reg.mode == st_recover && s_reg.cnt == RECOVERY_CNT)
    else $error("hold exit did not start recovery");

  cnt_step_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_recover && !hold_req && s_reg.cnt > 6'h01)
    |=> s_reg.cnt == $past(s_reg.cnt) - 6'h01)
    else $error("recovery count did not step");

  cnt_bound_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1
    |-> s_reg.cnt <= RECOVERY_CNT)
    else $error("recovery count out of range");

  rehold_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_recover && hold_req)
    |=> s_reg.mode == st_hold)
    else $error("request in recovery did not hold");

  recover_freeze_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && s_reg.mode == st_recover)
    |=> $stable(s_reg.core) && $stable(s_reg.pad_dout) && $stable(s_reg.pad_oe))
    else $error("state changed during recovery");

  valid_flag_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1
    |-> in_hold != outputs_valid)
    else $error("valid and hold flags disagree");

endmodule // pin_power_down_hold

`default_nettype wire

// ---- sim/pd_driver.sv ----
// far-side model: the external system driving the power-down pin
`timescale 1ns/100ps
`default_nettype none
module pd_driver (
  input wire logic mclk,
  input wire logic req,
  output var logic power_down_pin
);
  initial power_down_pin = 1'b0;
  // the pin is a plain level that changes just after an edge
  always @(posedge mclk) power_down_pin <= req;
endmodule // pd_driver
`default_nettype wire

// ---- sim/tb_pin_power_down_hold.sv ----
// self-checking bench for the power-down hold block
`timescale 1ns/100ps
`default_nettype none
module tb_pin_power_down_hold;
  import pd_hold_pkg::*;
  logic mclk = 0, rst = 1, ce = 1, pd_enable = 1, req = 0, in_hold, outputs_valid, pin_cell_feedback, power_down_pin;
  logic [7:0] pad_in = 8'h00, out_data_in = 8'h00, out_oe_in = 8'h00, core_next_in = 8'h00, pad_seen, core_state;
  pad_out_t pad_out;
  logic [31:0] snap;
  int failures = 0, total_checks = 0, n;
  pin_power_down_hold u_pin_power_down_hold (.mclk(mclk), .rst(rst), .ce(ce), .pd_enable(pd_enable),
    .power_down_pin(power_down_pin), .pad_in(pad_in), .core_next_in(core_next_in), .out_data_in(out_data_in),
    .out_oe_in(out_oe_in), .pad_seen(pad_seen), .core_state(core_state), .pad_out(pad_out), .in_hold(in_hold),
    .outputs_valid(outputs_valid), .pin_cell_feedback(pin_cell_feedback));
  pd_driver u_pd_driver (.mclk(mclk), .req(req), .power_down_pin(power_down_pin));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] outs();
    return {pad_seen, core_state, pad_out};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // new random inputs, then settle one capturing edge
  task automatic rnd();
    @(posedge mclk);
    pad_in <= $urandom;
    core_next_in <= $urandom;
    out_data_in <= $urandom;
    out_oe_in <= $urandom;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic run_flow(input int cnt);
    repeat (cnt) begin
      rnd();
      chk("core_state", core_next_in, core_state);
      chk("pad_out", {out_data_in, out_oe_in}, pad_out);
      chk("pad_seen", pad_in, pad_seen);
      chk("feedback", core_next_in[0], pin_cell_feedback);
      chk("in_hold", 0, in_hold);
    end
  endtask
  initial begin
    void'($urandom(73544));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    run_flow(20);
    $display("test run done");
    snap = outs();
    @(posedge mclk);
    ce <= 1'b0;
    repeat (4) begin
      rnd();
      chk("ce frozen", snap, outs());
    end
    @(posedge mclk);
    ce <= 1'b1;
    $display("test clock enable done");
    @(posedge mclk);
    pd_enable <= 1'b0;
    req <= 1'b1;
    run_flow(6);
    $display("test option off done");
    @(posedge mclk);
    pd_enable <= 1'b1;
    out_oe_in <= 8'h0f;
    for (n = 0; n < 10 && in_hold !== 1'b1; n++) @(negedge mclk);
    chk("hold entry", 1, in_hold);
    if (in_hold !== 1'b1) give_verdict();
    snap = outs();
    repeat (10) begin
      rnd();
      chk("held outputs", snap, outs());
      chk("high-z kept", 4'h0, pad_out.oe[7:4]);
    end
    $display("test hold done");
    @(posedge mclk);
    req <= 1'b0;
    for (n = 0; n < 100 && outputs_valid !== 1'b1; n++) begin
      rnd();
      chk("recover frozen", snap, outs());
    end
    chk("recovery time", (RECOVERY_CYC + 2) / 2, n);
    if (outputs_valid !== 1'b1) give_verdict();
    run_flow(3);
    $display("test recovery done");
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("reset outputs", {IO_RESET, CORE_RESET, IO_RESET, IO_RESET}, outs());
    chk("reset hold", 0, in_hold);
    @(posedge mclk);
    rst <= 1'b0;
    run_flow(2);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_pin_power_down_hold
`default_nettype wire
